// file: src/pixel_clock_out_pkg.sv
// package for the output pixel clock and spoof-frame block
// assumes the register port carries 16-bit data at 8-bit register numbers
package pixel_clock_out_pkg;
  localparam logic [7:0] OFS_CLK12 = 8'h0e;
  localparam logic [7:0] OFS_CLK3 = 8'h0f;
  localparam logic [7:0] OFS_WIDTH = 8'h10;
  localparam logic [7:0] OFS_HEIGHT = 8'h11;
  localparam logic [15:0] CLK12_RST = 16'h0501;
  localparam logic [7:0] CLK3_RST = 8'h03;
  localparam logic [11:0] WIDTH_RST = 12'h640;
  localparam logic [11:0] HEIGHT_RST = 12'h258;
  // field positions
  localparam int DIV_ONE_LSB = 0;
  localparam int SLEW_ONE_LSB = 5;
  localparam int DIV_TWO_LSB = 8;
  localparam int SLEW_TWO_LSB = 13;
  localparam int DIV_THREE_LSB = 0;
  localparam int SLEW_THREE_LSB = 5;
  typedef enum logic [1:0] {SRC_ONE, SRC_TWO, SRC_THREE} src_e;
  typedef enum logic [1:0] {FR_IDLE, FR_LINE, FR_GAP} frame_e;
endpackage : pixel_clock_out_pkg

// file: src/pixel_clock_out_spoof.sv
// output pixel clock generation with adaptive source selection, and spoof framing
// assumes all inputs are synchronous to clk_sys; buffer level comes from the output buffer
`timescale 1ns/1ps
// Function
// (RL1) second source divides master clock by bits 11:8, reset 5, zero means one.
// (RL2) adaptive: first source steps to second at half buffer fullness.
// (RL3) third source divides master clock by bits 3:0, reset 3, zero means one.
// (RL4) adaptive: second source steps to third at three quarters fullness.
// (RL5) output slew follows the setting of the source currently in use.
// (RL6) each line-valid assertion carries exactly spoof-width data bytes.
// (RL7) software programs the spoof width with an even byte count.
// (RL8) spoof height field is 12 bits, reset value 600.
// (RL9) height lines per frame, unless ignore-height set.
// (RL10) step down below half and below quarter; every frame starts on first source.
// (RL11) first source divides master clock by its divisor, zero means one.
// (RL12) source changes only at an output clock period boundary.
module pixel_clock_out_spoof #(
  parameter int LVL_W = 11,
  parameter int DEPTH = 1024
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  output logic [15:0] reg_rdata,
  input wire logic adaptive_en,
  input wire logic spoof_en,
  input wire logic ignore_height,
  input wire logic [LVL_W-1:0] buf_level,
  input wire logic frame_start,
  input wire logic data_done,
  input wire logic [7:0] byte_in,
  input wire logic byte_in_valid,
  output logic byte_take,
  output logic pixel_clock_out,
  output logic [2:0] slew_out,
  output logic frame_valid,
  output logic line_valid,
  output logic [7:0] data_out
);
  // a full buffer level must itself be representable on buf_level
  if (LVL_W < 2 || DEPTH < 4 || DEPTH >= (1 << LVL_W)) begin : g_bad_cfg
    $error("pixel_clock_out_spoof: DEPTH must be below 2**LVL_W and at least 4");
  end

  logic [15:0] clk12_r;
  logic [7:0] clk3_r;
  logic [11:0] width_r;
  logic [11:0] height_r;
  logic [15:0] rdata_r;
  pixel_clock_out_pkg::src_e src_r;
  pixel_clock_out_pkg::src_e src_nxt;
  pixel_clock_out_pkg::frame_e fr_r;
  logic [3:0] cur_div_r;
  logic [3:0] div_cnt_r;
  logic pclk_r;
  logic [2:0] slew_r;
  logic start_pend_r;
  logic fv_r;
  logic lv_r;
  logic [7:0] dout_r;
  logic take_r;
  logic [11:0] byte_cnt_r;
  logic [11:0] line_cnt_r;

  // effective divisors, zero behaves as one
  wire [3:0] raw_one = clk12_r[pixel_clock_out_pkg::DIV_ONE_LSB +: 4];
  wire [3:0] raw_two = clk12_r[pixel_clock_out_pkg::DIV_TWO_LSB +: 4];
  wire [3:0] raw_three = clk3_r[pixel_clock_out_pkg::DIV_THREE_LSB +: 4];
  wire [3:0] eff_one = (raw_one == 4'h0) ? 4'h1 : raw_one; // RL11
  wire [3:0] eff_two = (raw_two == 4'h0) ? 4'h1 : raw_two; // RL1
  wire [3:0] eff_three = (raw_three == 4'h0) ? 4'h1 : raw_three; // RL3
  wire [2:0] slew_one = clk12_r[pixel_clock_out_pkg::SLEW_ONE_LSB +: 3];
  wire [2:0] slew_two = clk12_r[pixel_clock_out_pkg::SLEW_TWO_LSB +: 3];
  wire [2:0] slew_three = clk3_r[pixel_clock_out_pkg::SLEW_THREE_LSB +: 3];

  // fullness thresholds, widened so the products cannot overflow
  wire [LVL_W+2:0] lvl2 = {2'h0, buf_level, 1'h0};
  wire [LVL_W+2:0] lvl4 = {1'h0, buf_level, 2'h0};
  wire [LVL_W+2:0] dep1 = (LVL_W+3)'(DEPTH);
  wire [LVL_W+2:0] dep3 = (LVL_W+3)'(3 * DEPTH);
  wire at_half = lvl2 >= dep1;
  wire at_3q = lvl4 >= dep3;
  wire below_q = lvl4 < dep1;

  wire tick = (div_cnt_r == cur_div_r - 4'h1);
  wire start_take = tick && start_pend_r && spoof_en && (fr_r == pixel_clock_out_pkg::FR_IDLE);
  wire wr_clk12 = reg_wr && (reg_addr == pixel_clock_out_pkg::OFS_CLK12);
  wire wr_clk3 = reg_wr && (reg_addr == pixel_clock_out_pkg::OFS_CLK3);
  wire wr_width = reg_wr && (reg_addr == pixel_clock_out_pkg::OFS_WIDTH);
  wire wr_height = reg_wr && (reg_addr == pixel_clock_out_pkg::OFS_HEIGHT);
  wire line_more = byte_cnt_r != width_r;
  // byte_take is seen one cycle late, so at divisor one every other byte is padding
  // rather than a repeat of the byte just consumed
  wire byte_ok = byte_in_valid && !take_r;
  wire frame_over = ignore_height ? data_done : (line_cnt_r == height_r); // RL9

  // one step per period, so a jump from first to third passes through second
  always_comb begin
    src_nxt = src_r;
    if (start_take || !adaptive_en) begin
      src_nxt = pixel_clock_out_pkg::SRC_ONE; // RL10
    end else begin
      case (src_r)
        pixel_clock_out_pkg::SRC_ONE: if (at_half) src_nxt = pixel_clock_out_pkg::SRC_TWO; // RL2
        pixel_clock_out_pkg::SRC_TWO: begin
          if (at_3q) src_nxt = pixel_clock_out_pkg::SRC_THREE; // RL4
          else if (below_q) src_nxt = pixel_clock_out_pkg::SRC_ONE; // RL10
        end
        pixel_clock_out_pkg::SRC_THREE: if (!at_half) src_nxt = pixel_clock_out_pkg::SRC_TWO; // RL10
        default: src_nxt = pixel_clock_out_pkg::SRC_ONE;
      endcase
    end
  end

  wire [3:0] div_nxt = (src_nxt == pixel_clock_out_pkg::SRC_TWO) ? eff_two :
                       (src_nxt == pixel_clock_out_pkg::SRC_THREE) ? eff_three : eff_one;
  wire [2:0] slew_nxt = (src_nxt == pixel_clock_out_pkg::SRC_TWO) ? slew_two :
                        (src_nxt == pixel_clock_out_pkg::SRC_THREE) ? slew_three : slew_one;
  wire [3:0] cnt_nxt = tick ? 4'h0 : div_cnt_r + 4'h1;
  wire [3:0] div_use = tick ? div_nxt : cur_div_r;
  // low for the first half of a period, data moves at the falling edge
  wire pclk_nxt = cnt_nxt >= {1'h0, div_use[3:1]};

  wire [15:0] rd_mux = (reg_addr == pixel_clock_out_pkg::OFS_CLK12) ? clk12_r :
                       (reg_addr == pixel_clock_out_pkg::OFS_CLK3) ? {8'h00, clk3_r} :
                       (reg_addr == pixel_clock_out_pkg::OFS_WIDTH) ? {4'h0, width_r} :
                       (reg_addr == pixel_clock_out_pkg::OFS_HEIGHT) ? {4'h0, height_r} : 16'h0000;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk12_r <= pixel_clock_out_pkg::CLK12_RST;
      clk3_r <= pixel_clock_out_pkg::CLK3_RST;
      width_r <= pixel_clock_out_pkg::WIDTH_RST;
      height_r <= pixel_clock_out_pkg::HEIGHT_RST; // RL8
      rdata_r <= 16'h0000;
    end else begin
      if (wr_clk12) clk12_r <= reg_wdata & 16'hefff;
      if (wr_clk3) clk3_r <= reg_wdata[7:0] & 8'hef;
      if (wr_width) width_r <= reg_wdata[11:0];
      if (wr_height) height_r <= reg_wdata[11:0];
      rdata_r <= rd_mux;
    end
  end

  // divisor and slew are only reloaded when a period has completed
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      src_r <= pixel_clock_out_pkg::SRC_ONE;
      cur_div_r <= 4'h1;
      div_cnt_r <= 4'h0;
      pclk_r <= 1'b1;
      slew_r <= 3'h0;
      start_pend_r <= 1'b0;
    end else begin
      div_cnt_r <= cnt_nxt;
      pclk_r <= pclk_nxt;
      if (tick) begin
        src_r <= src_nxt; // RL12
        cur_div_r <= div_nxt; // RL12
        slew_r <= slew_nxt; // RL5
      end
      // a new request wins over the take in the same cycle
      if (frame_start) start_pend_r <= 1'b1;
      else if (start_take) start_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fr_r <= pixel_clock_out_pkg::FR_IDLE;
      fv_r <= 1'b0;
      lv_r <= 1'b0;
      dout_r <= 8'h00;
      take_r <= 1'b0;
      byte_cnt_r <= 12'h000;
      line_cnt_r <= 12'h000;
    end else begin
      take_r <= 1'b0;
      if (tick) begin
        case (fr_r)
          pixel_clock_out_pkg::FR_IDLE: begin
            if (start_take) begin
              fv_r <= 1'b1;
              byte_cnt_r <= 12'h000;
              line_cnt_r <= 12'h000;
              fr_r <= pixel_clock_out_pkg::FR_LINE;
            end
          end
          pixel_clock_out_pkg::FR_LINE: begin
            if (line_more) begin
              // starved lines are padded with zero bytes up to the width
              lv_r <= 1'b1; // RL6
              dout_r <= byte_ok ? byte_in : 8'h00;
              take_r <= byte_ok;
              byte_cnt_r <= byte_cnt_r + 12'h001; // RL6
            end else begin
              lv_r <= 1'b0;
              line_cnt_r <= line_cnt_r + 12'h001;
              fr_r <= pixel_clock_out_pkg::FR_GAP;
            end
          end
          pixel_clock_out_pkg::FR_GAP: begin
            byte_cnt_r <= 12'h000;
            if (frame_over) begin
              fv_r <= 1'b0; // RL9
              fr_r <= pixel_clock_out_pkg::FR_IDLE;
            end else begin
              fr_r <= pixel_clock_out_pkg::FR_LINE;
            end
          end
          default: fr_r <= pixel_clock_out_pkg::FR_IDLE;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign byte_take = take_r;
  assign pixel_clock_out = pclk_r;
  assign slew_out = slew_r;
  assign frame_valid = fv_r;
  assign line_valid = lv_r;
  assign data_out = dout_r;

  // helper logic for the checks below
  logic height_wr_seen_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) height_wr_seen_r <= 1'b0;
    else if (wr_height) height_wr_seen_r <= 1'b1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  div_one_a: assert property ($past(tick) && src_r == pixel_clock_out_pkg::SRC_ONE // RL11
    |-> cur_div_r == (($past(raw_one) == 4'h0) ? 4'h1 : $past(raw_one)))
    else $error("first divisor wrong");
  div_two_a: assert property ($past(tick) && src_r == pixel_clock_out_pkg::SRC_TWO // RL1
    |-> cur_div_r == (($past(raw_two) == 4'h0) ? 4'h1 : $past(raw_two)))
    else $error("second divisor wrong");
  div_three_a: assert property ($past(tick) && src_r == pixel_clock_out_pkg::SRC_THREE // RL3
    |-> cur_div_r == (($past(raw_three) == 4'h0) ? 4'h1 : $past(raw_three)))
    else $error("third divisor wrong");
  up_two_a: assert property (tick && adaptive_en && !start_take && src_r == pixel_clock_out_pkg::SRC_ONE // RL2
    && at_half |=> src_r == pixel_clock_out_pkg::SRC_TWO) else $error("no step to second source");
  up_three_a: assert property (tick && adaptive_en && !start_take // RL4
    && src_r == pixel_clock_out_pkg::SRC_TWO && at_3q |=> src_r == pixel_clock_out_pkg::SRC_THREE)
    else $error("no step to third source");
  down_two_a: assert property (tick && adaptive_en && !start_take // RL10
    && src_r == pixel_clock_out_pkg::SRC_THREE && !at_half |=> src_r == pixel_clock_out_pkg::SRC_TWO)
    else $error("no step down from third source");
  frame_first_a: assert property ($rose(fv_r) |-> src_r == pixel_clock_out_pkg::SRC_ONE) // RL10
    else $error("frame did not start on first source");
  slew_sel_a: assert property ($past(tick) |-> slew_r == // RL5
    ((src_r == pixel_clock_out_pkg::SRC_TWO) ? $past(slew_two) :
     (src_r == pixel_clock_out_pkg::SRC_THREE) ? $past(slew_three) : $past(slew_one)))
    else $error("slew does not match source");
  line_len_a: assert property ($fell(lv_r) |-> byte_cnt_r == width_r) // RL6
    else $error("line length differs from width");
  height_rst_a: assert property (!height_wr_seen_r |-> height_r == 12'h258) // RL8
    else $error("height reset value wrong");
  line_count_a: assert property ($fell(fv_r) && !$past(ignore_height) // RL9
    |-> line_cnt_r == $past(height_r)) else $error("wrong line count per frame");
  switch_edge_a: assert property (!$stable(src_r) |-> $past(tick)) // RL12
    else $error("source changed mid period");

  frame_done_c: cover property ($fell(fv_r));
  third_src_c: cover property (src_r == pixel_clock_out_pkg::SRC_THREE && fv_r);
  line_pad_c: cover property (lv_r && !take_r && $past(tick));
  ignore_end_c: cover property ($fell(fv_r) && ignore_height);
endmodule : pixel_clock_out_spoof

// file: tb/pix_host.sv
// host receiver model: counts lines and bytes of the current spoof frame
// assumes pixel clock and framing outputs are synchronous to clk_sys
`timescale 1ns/1ps
module pix_host (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pixel_clock_out,
  input wire logic frame_valid,
  input wire logic line_valid,
  input wire logic [7:0] data_out,
  output int line_count,
  output int byte_total,
  output int data_sig
);
  logic pclk_d;
  logic lv_d;
  logic fv_d;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pclk_d <= 1'b1;
      lv_d <= 1'b0;
      fv_d <= 1'b0;
      line_count <= 0;
      byte_total <= 0;
      data_sig <= 0;
    end else begin
      pclk_d <= pixel_clock_out;
      lv_d <= line_valid;
      fv_d <= frame_valid;
      if (frame_valid && !fv_d) begin
        line_count <= 0;
        byte_total <= 0;
        data_sig <= 0;
      end else begin
        // a byte is taken on each rising pixel clock inside a line
        if (pixel_clock_out && !pclk_d && line_valid) begin
          byte_total <= byte_total + 1;
          data_sig <= data_sig * 3 + data_out;
        end
        if (lv_d && !line_valid) line_count <= line_count + 1;
      end
    end
  end
endmodule : pix_host

// file: tb/tb.sv
// testbench for the output pixel clock and spoof-frame block
// assumes a single 20 MHz clock; data bytes come from an lfsr stream, withheld in one frame
`timescale 1ns/1ps
module tb;
  logic clk_sys = 0;
  logic nrst = 0;
  logic [7:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic adaptive_en = 0;
  logic spoof_en = 0;
  logic [10:0] buf_level = 0;
  logic frame_start = 0;
  logic [7:0] byte_in = 8'h2b;
  logic byte_in_valid = 1;
  logic ignore_height = 0;
  logic data_done = 0;
  int data_sig;
  logic [15:0] reg_rdata;
  logic byte_take, pixel_clock_out, frame_valid, line_valid;
  logic [2:0] slew_out;
  logic [7:0] data_out;
  logic [15:0] d;
  int n_errors = 0, cmp_count = 0, line_count, byte_total, takes = 0, p;
  logic [10:0] lv[6] = '{11'h000, 11'h200, 11'h300, 11'h258, 11'h190, 11'h064};
  int sl[6] = '{2, 5, 7, 7, 5, 2};
  int pr[6] = '{2, 4, 3, 3, 4, 2};
  logic [7:0] ad[4] = '{8'h0e, 8'h0f, 8'h10, 8'h11};
  logic [15:0] mk[4] = '{16'hefff, 16'h00ef, 16'h0fff, 16'h0fff};
  always #25 clk_sys = ~clk_sys;
  pixel_clock_out_spoof u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .adaptive_en(adaptive_en),
    .spoof_en(spoof_en), .ignore_height(ignore_height), .buf_level(buf_level),
    .frame_start(frame_start), .data_done(data_done), .byte_in(byte_in),
    .byte_in_valid(byte_in_valid), .byte_take(byte_take), .pixel_clock_out(pixel_clock_out),
    .slew_out(slew_out), .frame_valid(frame_valid), .line_valid(line_valid),
    .data_out(data_out));
  pix_host u_host (.clk_sys(clk_sys), .nrst(nrst), .pixel_clock_out(pixel_clock_out),
    .frame_valid(frame_valid), .line_valid(line_valid), .data_out(data_out),
    .line_count(line_count), .byte_total(byte_total), .data_sig(data_sig));
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  // signature of n bytes of the lfsr stream, folded the way the host folds them
  function automatic int exp_sig(input logic [7:0] b, input int n);
    int s;
    s = 0;
    for (int i = 0; i < n; i++) begin
      s = s * 3 + b;
      b = lfsr_next(b);
    end
    return s;
  endfunction : exp_sig
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    check(reg_rdata, exp);
  endtask : rd
  // period of the pixel clock in master cycles, rising edge to rising edge
  task automatic period(output int n);
    int k;
    int s;
    k = 0;
    s = 0;
    for (int i = 0; i < 2; i++) begin
      while (pixel_clock_out !== 1'b0 && k < 99) begin @(posedge clk_sys); k++; end
      while (pixel_clock_out !== 1'b1 && k < 99) begin @(posedge clk_sys); k++; end
      n = k - s;
      s = k;
    end
  endtask : period
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic run_frame(input int lines, input int bytes, input int sig);
    @(posedge clk_sys);
    frame_start <= 1'b1;
    @(posedge clk_sys);
    frame_start <= 1'b0;
    for (int k = 0; k < 60 && frame_valid !== 1'b1; k++) @(posedge clk_sys);
    for (int k = 0; k < 500 && frame_valid !== 1'b0; k++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    check(line_count, lines);
    check(byte_total, bytes);
    check(data_sig, sig);
  endtask : run_frame
  always @(posedge clk_sys) begin
    if (byte_take === 1'b1) begin
      takes++;
      byte_in <= lfsr_next(byte_in);
    end
  end
  initial begin
    #(50 * 20000);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'h0e, 16'h0501);
    rd(8'h0f, 16'h0003);
    rd(8'h10, 16'h0640);
    rd(8'h11, 16'h0258);
    rd(8'h20, 16'h0000);
    d = 16'h432b;
    for (int i = 0; i < 4; i++) begin
      d = {lfsr_next(d[15:8]), lfsr_next(d[7:0])};
      wr(ad[i], d);
      rd(ad[i], d & mk[i]);
    end
    $display("test registers done");
    // zero divisor on source one: the clock never drops
    wr(8'h0e, 16'ha440);
    repeat (10) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      check(pixel_clock_out, 1);
    end
    wr(8'h0e, 16'ha442);
    wr(8'h0f, 16'h00e3);
    adaptive_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      buf_level <= lv[i];
      repeat (30) @(posedge clk_sys);
      period(p);
      check(slew_out, sl[i]);
      check(p, pr[i]);
    end
    $display("test adaptive clock done");
    adaptive_en <= 1'b0;
    buf_level <= 11'h000;
    wr(8'h0e, 16'h0302);
    wr(8'h10, 16'h0006);
    wr(8'h11, 16'h0003);
    spoof_en <= 1'b1;
    run_frame(3, 18, exp_sig(byte_in, 18));
    check(takes, 18);
    $display("test spoof frame done");
    // frame requested on the third source starts on the first, ends on data exhaustion, and is all padding
    adaptive_en <= 1'b1;
    buf_level <= 11'h300;
    ignore_height <= 1'b1;
    data_done <= 1'b1;
    byte_in_valid <= 1'b0;
    repeat (30) @(posedge clk_sys);
    run_frame(1, 6, 0);
    check(takes, 18);
    $display("test padded frame done");
    close_out();
  end
endmodule : tb
